// *** shared/pidsv_pkg.sv ***
// Package for the single-axis servo loop core: timing, widths, reset values
// and the carrier structs shared between the core and its surroundings.
// Assumes a 250 MHz system clock and a signed, offset-free converter word.
package pidsv_pkg;

	// Clock and servo timing
	localparam int unsigned CLK_PERIOD_PS   = 4000;          // 4 ns system clock period
	localparam int unsigned SERVO_PERIOD_US = 400;           // Servo cycle as specified
	localparam int unsigned SERVO_CYCLES    =
		(SERVO_PERIOD_US * 1000000) / CLK_PERIOD_PS;         // 100000 clocks per cycle

	// Data widths
	localparam int unsigned POS_W  = 32;                     // Position counter width
	localparam int unsigned GAIN_W = 16;                     // Gain word width
	localparam int unsigned DAC_W  = 16;                     // Converter word width
	localparam int unsigned ACC_W  = 48;                     // Integral accumulator width
	localparam int unsigned SUM_W  = 64;                     // Internal sum width
	localparam int unsigned FRAC_W = 8;                      // Fixed-point gain fraction bits

	// Reset values
	localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;  // Position at power-on

	// Converter full-scale limits, signed
	localparam logic signed [DAC_W-1:0] DAC_MAX = 16'h7FFF;  // Positive full scale
	localparam logic signed [DAC_W-1:0] DAC_MIN = 16'h8000;  // Negative full scale
	localparam logic signed [DAC_W-1:0] DAC_ZERO = 16'h0000; // Idle output

	// Gain set supplied by the command side
	typedef struct packed {
		logic signed [GAIN_W-1:0] proportional_gain;         // Error gain
		logic signed [GAIN_W-1:0] integral_gain;             // Accumulator gain
		logic signed [GAIN_W-1:0] derivative_gain;           // Error-difference gain
		logic signed [GAIN_W-1:0] velocity_feedforward_gain; // Velocity gain
		logic signed [GAIN_W-1:0] accel_feedforward_gain;    // Acceleration gain
	} pidsv_gains_t;

	// Trajectory set points for the current servo cycle
	typedef struct packed {
		logic signed [POS_W-1:0] desired_position;           // Target position
		logic signed [POS_W-1:0] desired_velocity;           // Target velocity
		logic signed [POS_W-1:0] desired_accel;              // Target acceleration
	} pidsv_traj_t;

endpackage : pidsv_pkg

// *** hdl/pidsv_core.sv ***
// Servo loop core for one motion axis: quadrature position counter,
// PID computation with feed-forward, saturated converter word per cycle.
// Assumes gains and trajectory are steady from the same clock domain;
// encoder channels arrive asynchronously and are synchronised here.
//
// Summary of operation
// - Every 400 us, error = desired minus actual.
// - Proportional term is error times proportional gain.
// - Accumulate error each cycle; scale by integral gain.
// - Derivative term from error change, times gain.
// - Add proportional, integral, derivative into one control.
// - Present control word to converter each cycle.
// - Include velocity and acceleration feed-forward terms.
// - Desired velocity times feed-forward gain is added.
// - Quadrature counter tracks position, zero at reset.
`timescale 1ns/10ps

module pidsv_core #(
	parameter int unsigned SERVO_CYCLES = pidsv_pkg::SERVO_CYCLES // Clocks per servo cycle
) (
	input  wire logic                                clk_sys_i,   // 250 MHz system clock
	input  wire logic                                nrst_i,      // Async reset, active low
	input  wire logic                                enc_a_i,     // Encoder channel A, async
	input  wire logic                                enc_b_i,     // Encoder channel B, async
	input  wire pidsv_pkg::pidsv_gains_t             gains_i,     // Loop gains
	input  wire pidsv_pkg::pidsv_traj_t              traj_i,      // Trajectory set points
	output logic signed [pidsv_pkg::DAC_W-1:0]       dac_word_o,  // Converter word, registered
	output logic                                     dac_load_o,  // One-cycle converter load
	output logic signed [pidsv_pkg::POS_W-1:0]       position_o,  // Actual position counter
	output logic signed [pidsv_pkg::POS_W-1:0]       error_o      // Latest following error
);

	localparam int unsigned SUM_W  = pidsv_pkg::SUM_W;   // Internal width
	localparam int unsigned POS_W  = pidsv_pkg::POS_W;   // Position width
	localparam int unsigned ACC_W  = pidsv_pkg::ACC_W;   // Accumulator width
	localparam int unsigned TICK_W = $clog2(SERVO_CYCLES); // Tick counter width

	// Two-stage synchronisers for the encoder channels
	logic [1:0] enc_meta;   // First stage, read only by second
	logic [1:0] enc_sync;   // Second stage, safe to use
	logic [1:0] enc_prev;   // Last settled state for decoding

	// Synchroniser chain; nothing else looks at enc_meta
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enc_meta <= 2'h0;
			enc_sync <= 2'h0;
			enc_prev <= 2'h0;
		end else begin
			enc_meta <= {enc_a_i, enc_b_i};
			enc_sync <= enc_meta;
			enc_prev <= enc_sync;
		end
	end

	// Quadrature step decode: gray order 00,01,11,10 counts up
	logic step_up;   // Forward transition seen
	logic step_dn;   // Reverse transition seen
	always_comb begin
		step_up = (enc_prev == 2'h0 && enc_sync == 2'h1) || (enc_prev == 2'h1 && enc_sync == 2'h3) ||
		          (enc_prev == 2'h3 && enc_sync == 2'h2) || (enc_prev == 2'h2 && enc_sync == 2'h0);
		step_dn = (enc_prev == 2'h1 && enc_sync == 2'h0) || (enc_prev == 2'h3 && enc_sync == 2'h1) ||
		          (enc_prev == 2'h2 && enc_sync == 2'h3) || (enc_prev == 2'h0 && enc_sync == 2'h2);
	end

	// Position counter; a double step (illegal jump) is ignored
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			position_o <= pidsv_pkg::POS_RESET;
		end else if (step_up) begin
			position_o <= position_o + POS_W'(1);
		end else if (step_dn) begin
			position_o <= position_o - POS_W'(1);
		end
	end

	// Servo cycle tick generator
	logic [TICK_W-1:0] tick_cnt;   // Clocks into the current cycle
	logic              tick;       // One-cycle servo strobe
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_W'(SERVO_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + TICK_W'(1);
			tick     <= 1'b0;
		end
	end

	// Current error, formed from live position; latched on tick
	logic signed [POS_W-1:0] next_error;   // Desired minus actual
	assign next_error = traj_i.desired_position - position_o;

	// Error history and integrator; cleared by reset only
	logic signed [POS_W-1:0] prev_error;   // Error of the previous cycle
	logic signed [ACC_W-1:0] accum;        // Running error sum
	logic                    calc;         // Second stage of the pipeline
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			error_o    <= '0;
			prev_error <= '0;
			accum      <= '0;
			calc       <= 1'b0;
		end else begin
			calc <= tick;
			if (tick) begin
				error_o    <= next_error;
				prev_error <= error_o;
				accum      <= accum + ACC_W'(next_error);
			end
		end
	end

	// Term products, wide enough to never overflow
	logic signed [SUM_W-1:0] p_term;   // Proportional part
	logic signed [SUM_W-1:0] i_term;   // Integral part
	logic signed [SUM_W-1:0] d_term;   // Derivative part
	logic signed [SUM_W-1:0] v_term;   // Velocity feed-forward
	logic signed [SUM_W-1:0] a_term;   // Acceleration feed-forward
	logic signed [SUM_W-1:0] total;    // Sum before scaling
	logic signed [SUM_W-1:0] scaled;   // Sum after fraction shift
	always_comb begin
		p_term = SUM_W'(error_o) * SUM_W'(gains_i.proportional_gain);
		i_term = SUM_W'(accum) * SUM_W'(gains_i.integral_gain);
		d_term = SUM_W'(error_o - prev_error) * SUM_W'(gains_i.derivative_gain);
		v_term = SUM_W'(traj_i.desired_velocity) *
		         SUM_W'(gains_i.velocity_feedforward_gain);
		a_term = SUM_W'(traj_i.desired_accel) * SUM_W'(gains_i.accel_feedforward_gain);
		total  = p_term + i_term + d_term + v_term + a_term;
		scaled = total >>> pidsv_pkg::FRAC_W;
	end

	// Saturate to converter range rather than wrap
	logic signed [pidsv_pkg::DAC_W-1:0] next_dac;   // Clamped word
	always_comb begin
		if (scaled > SUM_W'(pidsv_pkg::DAC_MAX)) begin
			next_dac = pidsv_pkg::DAC_MAX;
		end else if (scaled < SUM_W'(pidsv_pkg::DAC_MIN)) begin
			next_dac = pidsv_pkg::DAC_MIN;
		end else begin
			next_dac = scaled[pidsv_pkg::DAC_W-1:0];
		end
	end

	// Converter word updates once per cycle with a load strobe
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dac_word_o <= pidsv_pkg::DAC_ZERO;
			dac_load_o <= 1'b0;
		end else begin
			dac_load_o <= calc;
			if (calc) begin
				dac_word_o <= next_dac;
			end
		end
	end

	// Load strobe follows each servo tick by exactly two clocks
	a_load_after_tick: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		tick |-> ##2 dac_load_o)
		else $error("converter load missing two clocks after tick");

	// Word changes only with a load strobe
	a_word_only_load: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		!dac_load_o |-> $stable(dac_word_o))
		else $error("converter word changed without load");

	// Error latched equals desired minus position at tick
	a_error_capture: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		tick |=> error_o == $past(traj_i.desired_position) - $past(position_o))
		else $error("following error not captured correctly");

	// Accumulator grows by the latched error each tick
	a_accum_adds: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		tick |=> accum == $past(accum) + ACC_W'(error_o))
		else $error("integrator did not add the error");

	// Previous error takes old error value on tick
	a_history_shift: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		tick |=> prev_error == $past(error_o))
		else $error("error history not shifted");

	// Unchanged error gives no derivative term
	a_deriv_zero: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(error_o == prev_error) |-> d_term == '0)
		else $error("derivative term nonzero for steady error");

	// Positive overflow clamps to the top of full scale
	a_word_clamped: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		calc && scaled > SUM_W'(pidsv_pkg::DAC_MAX) |=> dac_word_o == pidsv_pkg::DAC_MAX)
		else $error("positive overflow not saturated");

	// Forward step raises position by one
	a_pos_count: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		step_up |=> position_o == $past(position_o) + POS_W'(1))
		else $error("position did not count up");

	// No second tick in the two clocks after a tick
	a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		tick |=> !tick [*2])
		else $error("servo ticks too close");

	// Sum includes feed-forward velocity product
	a_sum_ff: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		total == p_term + i_term + d_term + a_term +
		         SUM_W'(traj_i.desired_velocity) * SUM_W'(gains_i.velocity_feedforward_gain))
		else $error("velocity feed-forward missing from sum");

	// Reverse step lowers position by one
	a_pos_count_dn: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		step_dn |=> position_o == $past(position_o) - POS_W'(1))
		else $error("position did not count down");

	// Negative overflow clamps to the bottom of full scale, never wraps
	a_word_clamp_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		calc && scaled < SUM_W'(pidsv_pkg::DAC_MIN) |=> dac_word_o == pidsv_pkg::DAC_MIN)
		else $error("negative overflow not saturated");

	// Load strobe lasts a single clock so the driver latches once per cycle
	a_load_single: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		dac_load_o |=> !dac_load_o)
		else $error("converter load longer than one clock");

endmodule : pidsv_core

// *** testbench/pidsv_axis_model.sv ***
// Far side of the servo core: incremental encoder plus analog motor driver.
// Assumes steps are issued from the bench at falling clock edges.
`timescale 1ns/10ps

module pidsv_axis_model (
	input  wire logic        clk_sys_i,  // System clock
	input  wire logic [15:0] dac_word_i, // Converter word from the core
	input  wire logic        dac_load_i, // One-cycle converter load
	output logic             enc_a_o,    // Encoder channel A
	output logic             enc_b_o     // Encoder channel B
);
	logic [1:0]  phase = 2'b00; // Quadrature phase index
	int          count = 0;     // Net counts issued
	logic [15:0] drive;         // Level held by the driver, unknown until first load

	// Gray order 00, 01, 11, 10 counts up, A is the upper bit
	assign enc_a_o = phase[1];
	assign enc_b_o = phase[1] ^ phase[0];

	// One step, then a quiet gap so the core's synchroniser settles
	task automatic step(input bit up);
		@(negedge clk_sys_i);
		phase = up ? phase + 2'd1 : phase - 2'd1;
		count += up ? 1 : -1;
		repeat (4) @(negedge clk_sys_i);
	endtask : step

	// Driver holds the last loaded word until the next load
	always_ff @(posedge clk_sys_i) begin
		if (dac_load_i) begin
			drive <= dac_word_i;
		end
	end
endmodule : pidsv_axis_model

// *** testbench/pidsv_core_tb.sv ***
// Self-checking bench for the servo core with a short servo period.
// Assumes the axis model for encoder and driver; inputs change at negedge.
`timescale 1ns/10ps

module pidsv_core_tb;
	localparam int SC = 16;          // Shortened servo period, clocks
	logic                  clk_sys_i = 1'b0; // System clock
	logic                  nrst_i = 1'b0;    // Reset, active low
	logic                  enc_a, enc_b;     // Encoder lines from model
	pidsv_pkg::pidsv_gains_t gains = '0;     // Loop gains
	pidsv_pkg::pidsv_traj_t  traj = '0;      // Set points
	logic signed [15:0]    dac_word_o;       // Converter word
	logic                  dac_load_o;       // Converter load
	logic signed [31:0]    position_o;       // Position counter
	logic signed [31:0]    error_o;          // Following error
	int                    fail_count = 0;   // Mismatches
	int                    checks = 0;       // Comparisons made
	int                    n;                // Clocks waited

	always #2 clk_sys_i = ~clk_sys_i; // 250 MHz

	pidsv_core #(.SERVO_CYCLES(SC)) i_pidsv_core (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .enc_a_i(enc_a), .enc_b_i(enc_b),
		.gains_i(gains), .traj_i(traj), .dac_word_o(dac_word_o),
		.dac_load_o(dac_load_o), .position_o(position_o), .error_o(error_o));

	pidsv_axis_model i_pidsv_axis_model (
		.clk_sys_i(clk_sys_i), .dac_word_i(dac_word_o), .dac_load_i(dac_load_o),
		.enc_a_o(enc_a), .enc_b_o(enc_b));

	// Compare 16-bit converter words
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// Compare 32-bit positions, errors and counts
	task automatic chk_pos(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_pos

	// Reset for 8 cycles, clearing integrator and history
	task automatic restart;
		@(negedge clk_sys_i);
		nrst_i = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		nrst_i = 1'b1;
	endtask : restart

	// Wait for the next load under a bound; n gives the clocks waited
	task automatic wait_load;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (dac_load_o !== 1'b1 && n < 100);
		if (n >= 100) chk_pos(32'(n), 32'h0000_0000); // Load never came
	endtask : wait_load

	task automatic t_reset;
		restart();
		chk_word(dac_word_o, 16'h0000);
		chk_pos(position_o, 32'h0000_0000);
		chk_pos(error_o, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset

	// Unit P, I and D gains on a steady error of 10
	task automatic t_pid;
		gains = '{16'h0100, 16'h0100, 16'h0100, 16'h0000, 16'h0000};
		traj = '{32'sh0000_000A, 32'sh0000_0000, 32'sh0000_0000};
		restart();
		wait_load();
		chk_word(dac_word_o, 16'h001E);
		chk_pos(error_o, 32'h0000_000A);
		wait_load();
		chk_pos(32'(n), 32'(SC));
		chk_word(dac_word_o, 16'h001E);
		wait_load();
		chk_word(dac_word_o, 16'h0028);
		@(negedge clk_sys_i); // Driver takes the word at the next rising edge
		chk_word(i_pidsv_axis_model.drive, 16'h0028);
		chk_word({15'h0000, dac_load_o}, 16'h0000);
		$display("pid test done");
	endtask : t_pid

	// Velocity gain 2 on 5 plus acceleration gain 1 on 3
	task automatic t_ff;
		gains = '{16'h0000, 16'h0000, 16'h0000, 16'h0200, 16'h0100};
		traj = '{32'sh0000_0000, 32'sh0000_0005, 32'sh0000_0003};
		repeat (2) wait_load();
		chk_word(dac_word_o, 16'h000D);
		$display("feed-forward test done");
	endtask : t_ff

	// Large errors clamp to both ends of full scale
	task automatic t_sat;
		gains = '{16'h7FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		traj = '{32'sh0010_0000, 32'sd0, 32'sd0};
		repeat (2) wait_load();
		chk_word(dac_word_o, 16'h7FFF);
		traj = '{-32'sh0010_0000, 32'sd0, 32'sd0};
		repeat (2) wait_load();
		chk_word(dac_word_o, 16'h8000);
		$display("saturation test done");
	endtask : t_sat

	// Three steps up, one down, then a negative error
	task automatic t_enc;
		gains = '{16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		traj = '0;
		repeat (3) i_pidsv_axis_model.step(1'b1);
		i_pidsv_axis_model.step(1'b0);
		chk_pos(position_o, 32'h0000_0002);
		chk_pos(position_o, 32'(i_pidsv_axis_model.count));
		repeat (2) wait_load();
		chk_pos(error_o, 32'hFFFF_FFFE);
		chk_word(dac_word_o, 16'hFFFE);
		$display("encoder test done");
	endtask : t_enc

	// Counts, verdict and end of run
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test

	// Whole run is a few hundred clocks; allow ample margin
	initial begin
		#20000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		t_reset();
		t_pid();
		t_ff();
		t_sat();
		t_enc();
		end_of_test();
	end
endmodule : pidsv_core_tb
